// ---- tb/e3dlr_far_end.sv ----
// far-end data-link transmitter model feeding overhead octets
`timescale 1ns/10ps
module e3dlr_far_end (
  input  wire logic       clk,
  output logic            ohValid,
  output logic      [7:0] gcByte,
  output logic      [7:0] nrByte
);
  logic bitQ[$];
  int   ones;
  initial begin
    ohValid = 1'b0;
    gcByte  = 8'h00;
    nrByte  = 8'hff;
  end
  task automatic put(input logic [7:0] v, input bit st);
    for (int i = 0; i < 8; i++) begin
      bitQ.push_back(v[i]);
      ones = (st && v[i]) ? ones + 1 : 0;
      if (ones == 5) begin
        bitQ.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  task automatic send(input logic [7:0] d[$], input bit raw, input bit bad, input bit nr);
    logic [15:0] crc;
    logic [7:0]  o;
    crc = e3dlr_pkg::CRC_INIT;
    ones = 0;
    put(e3dlr_pkg::FLAG_OCTET, 1'b0);
    foreach (d[k]) begin
      put(d[k], !raw);
      for (int i = 0; i < 8; i++)
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[k][i]) ? e3dlr_pkg::CRC_POLY : 16'h0);
    end
    crc = ~crc ^ {15'h0, bad};
    if (!raw) begin
      put(crc[15:8], 1'b1);
      put(crc[7:0], 1'b1);
    end
    put(e3dlr_pkg::FLAG_OCTET, 1'b0);
    while (bitQ.size() % 8 != 0)
      bitQ.push_back(1'b0);
    put(e3dlr_pkg::FLAG_OCTET, 1'b0);
    while (bitQ.size() > 0) begin
      for (int i = 0; i < 8; i++)
        o[i] = bitQ.pop_front();
      @(posedge clk);
      ohValid <= 1'b1;
      gcByte  <= nr ? ~o : o;
      nrByte  <= nr ? o : ~o;
      @(posedge clk);
      ohValid <= 1'b0;
      gcByte  <= ~gcByte;
      nrByte  <= ~nrByte;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule

// ---- tb/e3dlr_receiver_bench.sv ----
// self-checking bench of the e3 data-link receiver
`timescale 1ns/10ps
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); \
  end \
end
module e3dlr_receiver_bench;
  logic       clk, nrst, ohValid, wrEn, rdEn, irq;
  logic [7:0] gcByte, nrByte, wrData, rdData, rv;
  logic [8:0] addr;
  logic [7:0] fr[$];
  logic [7:0] mt[4];
  int         error_cnt, compares;
  e3dlr_receiver dut (.clk(clk), .nrst(nrst), .ohValid(ohValid), .gcByte(gcByte),
    .nrByte(nrByte), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .irq(irq));
  e3dlr_far_end far (.clk(clk), .ohValid(ohValid), .gcByte(gcByte), .nrByte(nrByte));
  always #2 clk = ~clk;
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wrEn   <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask
  task automatic chkrd(input logic [8:0] a, input logic [7:0] e);
    rd(a, rv);
    `CHK(rv, e);
  endtask
  // header, then type code and info
  task automatic mk(input logic [7:0] hdr, input logic [7:0] ty, input int n);
    fr = {hdr, 8'h01, 8'h03, ty};
    for (int k = 1; k < n; k++)
      fr.push_back(k[0] ? 8'hff : k[7:0]);
  endtask
  task automatic conclude();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 9'h000;
    wrData = 8'h00;
    mt = '{e3dlr_pkg::MT_CLPATH, e3dlr_pkg::MT_IDLE, e3dlr_pkg::MT_TEST,
      e3dlr_pkg::MT_ITUPATH};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chkrd(e3dlr_pkg::CTRL_OFS, 8'h02);
    chkrd(9'h1f0, 8'h00);
    mk(8'h3c, e3dlr_pkg::MT_CLPATH, 76);
    far.send(fr, 1'b0, 1'b0, 1'b0);
    chkrd(e3dlr_pkg::STAT_OFS, 8'h00);
    `CHK(irq, 1'b0);
    for (int t = 0; t < 4; t++) begin
      mk(t[0] ? 8'h3e : 8'h3c, mt[t], t == 3 ? 82 : 76);
      wr(e3dlr_pkg::CTRL_OFS, {4'h0, t[1], 3'h2});
      wr(e3dlr_pkg::CTRL_OFS, {4'h0, t[1], 3'h6});
      far.send(fr, 1'b0, 1'b0, t[1]);
      chkrd(e3dlr_pkg::STAT_OFS, {2'b00, t[1:0], t[0], 3'b011});
      `CHK(irq, 1'b1);
      chkrd(e3dlr_pkg::CTRL_OFS, {4'h0, t[1], 3'h7});
      chkrd(e3dlr_pkg::CTRL_OFS, {4'h0, t[1], 3'h6});
      `CHK(irq, 1'b0);
      chkrd(e3dlr_pkg::EVT_OFS, 8'h03);
      wr(e3dlr_pkg::EVT_OFS, 8'h0f);
      for (int k = 0; k < fr.size() - 3; k++)
        chkrd(e3dlr_pkg::BUF_LO + 9'(k), fr[3 + k]);
    end
    wr(e3dlr_pkg::CTRL_OFS, 8'h04);
    wr(e3dlr_pkg::MASK_OFS, 8'h04);
    chkrd(e3dlr_pkg::MASK_OFS, 8'h04);
    mk(8'h3c, e3dlr_pkg::MT_IDLE, 76);
    far.send(fr, 1'b0, 1'b1, 1'b0);
    chkrd(e3dlr_pkg::STAT_OFS, 8'h17);
    `CHK(irq, 1'b1);
    chkrd(e3dlr_pkg::BUF_LO + 9'h004, fr[7]);
    wr(e3dlr_pkg::EVT_OFS, 8'h0f);
    chkrd(e3dlr_pkg::EVT_OFS, 8'h00);
    `CHK(irq, 1'b0);
    fr = {8'hff, 8'hff};
    far.send(fr, 1'b1, 1'b0, 1'b0);
    chkrd(e3dlr_pkg::EVT_OFS, 8'h09);
    rd(e3dlr_pkg::STAT_OFS, rv);
    `CHK(rv[6], 1'b1);
    conclude();
  end
endmodule

// ---- tb/e3dlr_receiver_chk.sv ----
// bound assertions on the e3 data-link receiver ports
`timescale 1ns/10ps
module e3dlr_receiver_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [8:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrEn,
  input wire logic       rdEn,
  input wire logic [7:0] rdData,
  input wire logic       irq
);
  logic [2:0] ctlReg;
  logic [3:0] maskReg;
  logic       everEn, rdC;
  assign rdC = rdEn && addr == e3dlr_pkg::CTRL_OFS;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctlReg  <= 3'h1;
      maskReg <= 4'h0;
      everEn  <= 1'b0;
    end else begin
      everEn <= everEn | ctlReg[1];
      if (wrEn && addr == e3dlr_pkg::CTRL_OFS) ctlReg <= wrData[3:1];
      if (wrEn && addr == e3dlr_pkg::MASK_OFS) maskReg <= wrData[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ctrl_rb;
    rdC |=> rdData[7:1] == {4'h0, $past(ctlReg)};
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("bad control");
  property p_flag_clr;
    rdC ##2 rdC |=> !rdData[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
  property p_mask_rb;
    rdEn && addr == e3dlr_pkg::MASK_OFS |=> rdData == {4'h0, $past(maskReg)};
  endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("bad mask");
  property p_irq_gate;
    (!ctlReg[0] && maskReg == 4'h0)[*2] |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  property p_idle;
    rdEn && addr == e3dlr_pkg::STAT_OFS && !everEn |=> rdData == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("status while idle");
  property p_stat_hi;
    rdEn && addr == e3dlr_pkg::STAT_OFS |=> !rdData[7];
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status bit 7 set");
  property p_unmap;
    rdEn && addr > e3dlr_pkg::BUF_HI |=> rdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_quiet;
    !rdEn |=> rdData == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray read data");
endmodule
bind e3dlr_receiver e3dlr_receiver_chk chk (.clk(clk), .nrst(nrst), .addr(addr),
  .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq));

// ---- verilog/e3dlr_crc_byte.sv ----
// one octet step of the frame check crc, octet fed lsb first
`timescale 1ns/10ps
module e3dlr_crc_byte #(
  parameter int          W    = 16,
  parameter logic [15:0] POLY = 16'h1021
) (
  input  wire logic [W-1:0] crcIn,
  input  wire logic [7:0]   dataIn,
  output logic      [W-1:0] crcOut
);
  always_comb begin
    logic [W-1:0] c;
    logic         fb;
    c  = crcIn;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[W-1] ^ dataIn[i];
      c  = {c[W-2:0], 1'b0} ^ (fb ? POLY[W-1:0] : '0);
    end
    crcOut = c;
  end
endmodule

// ---- verilog/e3dlr_pkg.sv ----
// constants and types of the e3 data-link message receiver
package e3dlr_pkg;
  localparam int          ADDR_W      = 9;
  localparam logic [8:0]  CTRL_OFS    = 9'h018;
  localparam logic [8:0]  STAT_OFS    = 9'h019;
  localparam logic [8:0]  EVT_OFS     = 9'h01a;
  localparam logic [8:0]  MASK_OFS    = 9'h01b;
  localparam logic [8:0]  BUF_LO      = 9'h0de;
  localparam logic [8:0]  BUF_HI      = 9'h135;
  localparam int          BUF_DEPTH   = 88;
  localparam logic [6:0]  BUF_DEPTH7  = 7'h58;
  // control register fields
  localparam int          CTL_NRSEL   = 3;
  localparam int          CTL_EN      = 2;
  localparam int          CTL_IRQEN   = 1;
  localparam int          CTL_IRQFLG  = 0;
  localparam logic [3:0]  CTRL_RST    = 4'h2;
  // event / mask register fields
  localparam int          EV_FLAG     = 0;
  localparam int          EV_EOM      = 1;
  localparam int          EV_FCSERR   = 2;
  localparam int          EV_ABORT    = 3;
  localparam logic [3:0]  EVT_RST     = 4'h0;
  localparam logic [3:0]  MASK_RST    = 4'h0;
  // line coding
  localparam logic [7:0]  FLAG_OCTET  = 8'h7e;
  localparam logic [2:0]  ABORT_ONES  = 3'h7;
  localparam logic [2:0]  FLAG_ONES   = 3'h6;
  localparam logic [2:0]  STUFF_ONES  = 3'h5;
  localparam logic [3:0]  OCTET_BITS  = 4'h8;
  localparam logic [7:0]  MIN_OCTETS  = 8'h05;
  localparam logic [7:0]  HDR_OCTETS  = 8'h03;
  localparam logic [7:0]  CR_INDEX    = 8'h00;
  localparam int          CR_BIT      = 1;
  localparam logic [7:0]  TYPE_INDEX  = 8'h03;
  // fcs
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  // message type codes and their status encodings
  localparam logic [7:0]  MT_CLPATH   = 8'h38;
  localparam logic [7:0]  MT_IDLE     = 8'h34;
  localparam logic [7:0]  MT_TEST     = 8'h32;
  localparam logic [7:0]  MT_ITUPATH  = 8'h3f;
  localparam logic [1:0]  TY_CLPATH   = 2'h0;
  localparam logic [1:0]  TY_IDLE     = 2'h1;
  localparam logic [1:0]  TY_TEST     = 2'h2;
  localparam logic [1:0]  TY_ITUPATH  = 2'h3;

  typedef struct packed {
    logic       abort;
    logic [1:0] msgType;
    logic       crType;
    logic       fcsErr;
    logic       message_end_flag;
    logic       flagSeen;
  } e3dlr_status_t;

  localparam e3dlr_status_t STAT_RST = 7'h00;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HUNT  = 2'b01,
    ST_FRAME = 2'b10
  } e3dlr_state_t;
endpackage

// ---- verilog/e3dlr_receiver.sv ----
// receive data-link message receiver for one e3 channel
// Function
// - stays idle until enabled, then hunts for flags in selected byte
// - 0x7e flag octets open and close each frame
// - information of 76 or 82 bytes, fcs msb first, closing flag
// - fcs is crc-16 with polynomial x16+x12+x5+1
// - information octets written to buffer at 0xde..0x135
// - each completed frame has crc recomputed and compared with fcs
// - status shows eom, flag, abort, message type, c/r and fcs error
// - select 0 takes gc byte, select 1 takes nr byte
// - control layout: select bit 3, enable 2, irq enable 1, flag 0
// - zero after five ones is dropped before storing data
// - seven ones after a flag flag an abort
// - fcs error set on mismatch, cleared on match, message kept
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module e3dlr_receiver (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ohValid,
  input  wire logic [7:0] gcByte,
  input  wire logic [7:0] nrByte,
  input  wire logic [8:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic      [7:0] rdData,
  output logic            irq
);
  e3dlr_pkg::e3dlr_state_t  state_reg,  state_next;
  e3dlr_pkg::e3dlr_status_t status_reg, status_next;
  logic [3:0]  ctrl_reg,    ctrl_next;
  logic [3:0]  evt_reg,     evt_next;
  logic [3:0]  mask_reg,    mask_next;
  logic [7:0]  shift_reg,   shift_next;
  logic [3:0]  bitCnt_reg,  bitCnt_next;
  logic [2:0]  ones_reg,    ones_next;
  logic [7:0]  assm_reg,    assm_next;
  logic [2:0]  assmCnt_reg, assmCnt_next;
  logic [7:0]  octCnt_reg,  octCnt_next;
  logic [7:0]  d1_reg,      d1_next;
  logic [7:0]  d2_reg,      d2_next;
  logic [15:0] crc_reg,     crc_next;
  logic [7:0]  rdData_reg,  rdData_next;
  logic        irq_reg,     irq_next;
  logic [7:0]  mem_reg [0:e3dlr_pkg::BUF_DEPTH-1];
  logic        memWe;
  logic [6:0]  memIdx;
  logic [15:0] crcStep;
  logic [3:0]  evSet;
  logic [7:0]  rdMux;
  logic        fcsBad;

  e3dlr_crc_byte #(
    .W    (16),
    .POLY (e3dlr_pkg::CRC_POLY)
  ) u_crc (
    .crcIn  (crc_reg),
    .dataIn (d2_reg),
    .crcOut (crcStep)
  );

  // line side: unpack bits, hunt flags, build octets
  always_comb begin
    logic       b;
    logic       newOctet;
    logic [7:0] octet;
    logic [7:0] idx;
    logic [7:0] bufIdx;
    b            = shift_reg[0];
    newOctet     = 1'b0;
    octet        = {b, assm_reg[7:1]};
    idx          = octCnt_reg - 8'h02;
    bufIdx       = octCnt_reg - e3dlr_pkg::MIN_OCTETS;
    state_next   = state_reg;
    status_next  = status_reg;
    shift_next   = shift_reg;
    bitCnt_next  = bitCnt_reg;
    ones_next    = ones_reg;
    assm_next    = assm_reg;
    assmCnt_next = assmCnt_reg;
    octCnt_next  = octCnt_reg;
    d1_next      = d1_reg;
    d2_next      = d2_reg;
    crc_next     = crc_reg;
    evSet        = 4'h0;
    memWe        = 1'b0;
    memIdx       = bufIdx[6:0];
    fcsBad       = (~crc_reg != {d2_reg, d1_reg});
    if (!ctrl_reg[e3dlr_pkg::CTL_EN]) begin
      state_next  = e3dlr_pkg::ST_IDLE;
      bitCnt_next = 4'h0;
      ones_next   = 3'h0;
    end else begin
      if (state_reg == e3dlr_pkg::ST_IDLE) begin
        state_next = e3dlr_pkg::ST_HUNT;
      end
      if (bitCnt_reg != 4'h0) begin
        shift_next  = {1'b0, shift_reg[7:1]};
        bitCnt_next = bitCnt_reg - 4'h1;
        if (b) begin
          if (ones_reg != e3dlr_pkg::ABORT_ONES) begin
            ones_next = ones_reg + 3'h1;
          end
          if (ones_reg == e3dlr_pkg::FLAG_ONES && state_reg == e3dlr_pkg::ST_FRAME) begin
            status_next.abort           = 1'b1;
            evSet[e3dlr_pkg::EV_ABORT]  = 1'b1;
            state_next                  = e3dlr_pkg::ST_HUNT;
          end else if (ones_reg < e3dlr_pkg::FLAG_ONES) begin
            newOctet = (assmCnt_reg == 3'h7);
          end
        end else begin
          ones_next = 3'h0;
          if (ones_reg == e3dlr_pkg::FLAG_ONES) begin
            status_next.flagSeen       = 1'b1;
            evSet[e3dlr_pkg::EV_FLAG]  = 1'b1;
            if (state_reg == e3dlr_pkg::ST_FRAME && octCnt_reg >= e3dlr_pkg::MIN_OCTETS) begin
              status_next.message_end_flag            = 1'b1;
              evSet[e3dlr_pkg::EV_EOM]   = 1'b1;
              status_next.fcsErr         = fcsBad;
              evSet[e3dlr_pkg::EV_FCSERR] = fcsBad;
            end
            state_next   = e3dlr_pkg::ST_FRAME;
            octCnt_next  = 8'h00;
            assmCnt_next = 3'h0;
            crc_next     = e3dlr_pkg::CRC_INIT;
          end else if (ones_reg != e3dlr_pkg::STUFF_ONES) begin
            newOctet = (assmCnt_reg == 3'h7);
          end
        end
        // stuffed zeros, flag-closing zeros and ones past the sixth not assembled
        if (b ? ones_reg < e3dlr_pkg::FLAG_ONES
              : (ones_reg != e3dlr_pkg::FLAG_ONES && ones_reg != e3dlr_pkg::STUFF_ONES)) begin
          assm_next    = octet;
          assmCnt_next = assmCnt_reg + 3'h1;
        end
      end
      // take gc or nr octet per frame
      if (ohValid) begin
        shift_next  = ctrl_reg[e3dlr_pkg::CTL_NRSEL] ? nrByte : gcByte;
        bitCnt_next = e3dlr_pkg::OCTET_BITS;
      end
    end
    if (newOctet && state_reg == e3dlr_pkg::ST_FRAME) begin
      d1_next = octet;
      d2_next = d1_reg;
      if (octCnt_reg != 8'hff) begin
        octCnt_next = octCnt_reg + 8'h01;
      end
      if (octCnt_reg == 8'h00) begin
        status_next.flagSeen = 1'b0;
        status_next.abort    = 1'b0;
      end
      if (octCnt_reg >= 8'h02) begin
        crc_next = crcStep;
        // c/r bit of first header octet
        if (idx == e3dlr_pkg::CR_INDEX) begin
          status_next.crType = d2_reg[e3dlr_pkg::CR_BIT];
        end
        if (idx == e3dlr_pkg::TYPE_INDEX) begin
          unique case (d2_reg)
            e3dlr_pkg::MT_IDLE:    status_next.msgType = e3dlr_pkg::TY_IDLE;
            e3dlr_pkg::MT_TEST:    status_next.msgType = e3dlr_pkg::TY_TEST;
            e3dlr_pkg::MT_ITUPATH: status_next.msgType = e3dlr_pkg::TY_ITUPATH;
            default:               status_next.msgType = e3dlr_pkg::TY_CLPATH;
          endcase
        end
        if (octCnt_reg >= e3dlr_pkg::MIN_OCTETS && bufIdx < {1'b0, e3dlr_pkg::BUF_DEPTH7}) begin
          memWe = 1'b1;
        end
      end
    end else if (newOctet) begin
      status_next.flagSeen = 1'b0;
    end
  end

  // bus side: control, events, mask, interrupt
  always_comb begin
    ctrl_next   = ctrl_reg;
    mask_next   = mask_reg;
    evt_next    = evt_reg;
    if (wrEn && addr == e3dlr_pkg::CTRL_OFS) begin
      ctrl_next[3:1] = wrData[3:1];
    end
    if (wrEn && addr == e3dlr_pkg::MASK_OFS) begin
      mask_next = wrData[3:0];
    end
    if (wrEn && addr == e3dlr_pkg::EVT_OFS) begin
      evt_next = evt_reg & ~wrData[3:0];
    end
    evt_next = evt_next | evSet;
    // flag clears on read, set wins
    if (rdEn && addr == e3dlr_pkg::CTRL_OFS) begin
      ctrl_next[e3dlr_pkg::CTL_IRQFLG] = 1'b0;
    end
    if (evSet[e3dlr_pkg::EV_EOM]) begin
      ctrl_next[e3dlr_pkg::CTL_IRQFLG] = 1'b1;
    end
    irq_next = (ctrl_next[e3dlr_pkg::CTL_IRQFLG] & ctrl_next[e3dlr_pkg::CTL_IRQEN])
             | (|(evt_next & mask_next));
  end

  // read data mux, shown one cycle after the strobe
  always_comb begin
    logic       hitBuf;
    logic [8:0] bOfs;
    hitBuf      = (addr >= e3dlr_pkg::BUF_LO) && (addr <= e3dlr_pkg::BUF_HI);
    bOfs        = addr - e3dlr_pkg::BUF_LO;
    rdMux       = 8'h00;
    if (rdEn) begin
      if (addr == e3dlr_pkg::CTRL_OFS) begin
        rdMux = {4'h0, ctrl_reg};
      end else if (addr == e3dlr_pkg::STAT_OFS) begin
        rdMux = {1'b0, status_reg};
      end else if (addr == e3dlr_pkg::EVT_OFS) begin
        rdMux = {4'h0, evt_reg};
      end else if (addr == e3dlr_pkg::MASK_OFS) begin
        rdMux = {4'h0, mask_reg};
      end else if (hitBuf) begin
        rdMux = mem_reg[bOfs[6:0]];
      end
    end
    rdData_next = rdMux;
  end

  // line side registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg   <= e3dlr_pkg::ST_IDLE;
      status_reg  <= e3dlr_pkg::STAT_RST;
      shift_reg   <= 8'h00;
      bitCnt_reg  <= 4'h0;
      ones_reg    <= 3'h0;
      assm_reg    <= 8'h00;
      assmCnt_reg <= 3'h0;
      octCnt_reg  <= 8'h00;
      d1_reg      <= 8'h00;
      d2_reg      <= 8'h00;
      crc_reg     <= e3dlr_pkg::CRC_INIT;
    end else begin
      state_reg   <= state_next;
      status_reg  <= status_next;
      shift_reg   <= shift_next;
      bitCnt_reg  <= bitCnt_next;
      ones_reg    <= ones_next;
      assm_reg    <= assm_next;
      assmCnt_reg <= assmCnt_next;
      octCnt_reg  <= octCnt_next;
      d1_reg      <= d1_next;
      d2_reg      <= d2_next;
      crc_reg     <= crc_next;
    end
  end

  // bus side registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg    <= e3dlr_pkg::CTRL_RST;
      evt_reg     <= e3dlr_pkg::EVT_RST;
      mask_reg    <= e3dlr_pkg::MASK_RST;
      rdData_reg  <= 8'h00;
      irq_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      evt_reg     <= evt_next;
      mask_reg    <= mask_next;
      rdData_reg  <= rdData_next;
      irq_reg     <= irq_next;
    end
  end

  // buffer write
  // message buffer, written regardless of fcs result
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem_reg[memIdx] <= d2_reg;
    end
  end

  assign rdData = rdData_reg;
  assign irq    = irq_reg;
endmodule
